// File: logic/mfr_top.sv
// Holds the monitor fault reaction map: the reaction register, the event
// status with interrupt, and the registered reset and fail-safe outputs.
// Assumes monitor detections are levels synchronous to CLOCK_I.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "mfr_defines.svh"

module mfr_top
  import mfr_pkg::*;
(
  input  wire logic               CLOCK_I,
  input  wire logic               NRST_I,
  input  wire mfr_pkg::addr_type  ADDR_I,
  input  wire mfr_pkg::word_type  WDATA_I,
  input  wire logic               WR_I,
  input  wire logic               RD_I,
  input  wire mfr_pkg::mon_type   MON_UV_I,
  input  wire mfr_pkg::mon_type   MON_OV_I,
  output mfr_pkg::word_type       RDATA_O,
  output logic                    SYSTEM_RESET_OUT_N_O,
  output logic                    FAIL_SAFE_OUT_N_O,
  output logic                    IRQ_O
);

  import mfr_pkg::*;

  state_type st;
  state_type next_st;
  event_type events;
  logic      reset_req;
  logic      fs_req;

  // Event vector in field order: even bits under-voltage, odd over-voltage.
  always_comb begin
    for (int m = 0; m < 4; m++) begin
      events[2*m]   = MON_UV_I[m];
      events[2*m+1] = MON_OV_I[m];
    end
  end

  // Each active event asks for what its reaction field selects.
  mfr_decode u_decode (
    .events_i    (events),
    .reaction_i  (st.reaction),
    .reset_req_o (reset_req),
    .fs_req_o    (fs_req)
  );

  // Places the reaction fields at their bus word bit positions.
  function automatic word_type react_word(input react_type r);
    react_word = '0;
    react_word[`MFR_REACT_LSB +: `MFR_REACT_W] = r;
  endfunction

  // Next state: register access, sticky status, output drive.
  always_comb begin
    next_st       = st;
    next_st.rdata = '0;
    // Reads answer in the next cycle; unmapped offsets read zero.
    if (RD_I) begin
      case (ADDR_I)
        `MFR_OFS_REACTION: next_st.rdata = react_word(st.reaction);
        `MFR_OFS_STATUS:   next_st.rdata = {24'h000000, st.status};
        `MFR_OFS_MASK:     next_st.rdata = {24'h000000, st.mask};
        `MFR_OFS_LIVE:     next_st.rdata = {21'h0, st.irq,
                                            st.fs_n, st.rst_n, events};
        default:           next_st.rdata = '0;
      endcase
    end
    // Writes; status bits clear on a one, a new event wins the cycle.
    next_st.status = st.status | events;
    if (WR_I) begin
      case (ADDR_I)
        `MFR_OFS_REACTION:
          next_st.reaction =
            WDATA_I[`MFR_REACT_LSB +: `MFR_REACT_W];
        `MFR_OFS_STATUS:
          next_st.status = (st.status & ~WDATA_I[7:0]) | events;
        `MFR_OFS_MASK:
          next_st.mask = WDATA_I[7:0];
        default: ;
      endcase
    end
    // Reset and fail-safe are active low and follow the live detections; the interrupt follows the sticky status.
    next_st.rst_n = ~reset_req;
    next_st.fs_n  = ~fs_req;
    next_st.irq   = |(next_st.status & next_st.mask);
    // Synchronous reset puts the defaults in place.
    if (!NRST_I) begin
      next_st.reaction = `MFR_REACT_RESET;
      next_st.status   = `MFR_STATUS_RESET;
      next_st.mask     = `MFR_MASK_RESET;
      next_st.rdata    = '0;
      next_st.rst_n    = 1'b1;
      next_st.fs_n     = 1'b1;
      next_st.irq      = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge CLOCK_I) begin
    st <= next_st;
  end

  // Every output comes straight from the state register.
  assign RDATA_O              = st.rdata;
  assign SYSTEM_RESET_OUT_N_O = st.rst_n;
  assign FAIL_SAFE_OUT_N_O    = st.fs_n;
  assign IRQ_O                = st.irq;

  // Checks run on the block clock and, except the reset check, rest while reset is held.
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!NRST_I);

  // Monitor one under-voltage drives fail-safe from code 01 up, and reset from code 10 up.
  // Alone at code 01 it must leave reset released; other events may not.
  a_one_under_react: assert property (
    MON_UV_I[0] && st.reaction[1:0] != `MFR_REACT_NONE && !WR_I
    |=> !FAIL_SAFE_OUT_N_O &&
        ($past(st.reaction[1]) ? !SYSTEM_RESET_OUT_N_O :
         ($past(events) != 8'h01 || SYSTEM_RESET_OUT_N_O)))
    else $error("monitor one under-voltage reaction wrong");

  // Monitor one over-voltage alone at 01 drives fail-safe only.
  a_one_over_fs: assert property (
    events == 8'h02 && st.reaction[3:2] == `MFR_REACT_FS && !WR_I
    |=> !FAIL_SAFE_OUT_N_O && SYSTEM_RESET_OUT_N_O)
    else $error("monitor one over-voltage fail-safe only broken");

  // Monitor one over-voltage at 10 or 11 drives both outputs.
  a_one_over_react: assert property (
    MON_OV_I[0] && st.reaction[3] && !WR_I
    |=> !FAIL_SAFE_OUT_N_O && !SYSTEM_RESET_OUT_N_O)
    else $error("monitor one over-voltage reaction wrong");

  // Monitor two under-voltage at 01 alone leaves reset released.
  a_two_under_fs: assert property (
    events == 8'h04 && st.reaction[5:4] == `MFR_REACT_FS && !WR_I
    |=> !FAIL_SAFE_OUT_N_O && SYSTEM_RESET_OUT_N_O)
    else $error("monitor two under-voltage fail-safe only broken");

  // Monitor two under-voltage at 10 or 11 drives both outputs.
  a_two_under_both: assert property (
    MON_UV_I[1] && st.reaction[5] && !WR_I
    |=> !FAIL_SAFE_OUT_N_O && !SYSTEM_RESET_OUT_N_O)
    else $error("monitor two under-voltage reaction wrong");

  // Monitor two over-voltage alone at 01 drives fail-safe only.
  a_two_over_fs: assert property (
    events == 8'h08 && st.reaction[7:6] == `MFR_REACT_FS && !WR_I
    |=> !FAIL_SAFE_OUT_N_O && SYSTEM_RESET_OUT_N_O)
    else $error("monitor two over-voltage fail-safe only broken");

  // Monitor two over-voltage at 10 or 11 drives both outputs.
  a_two_over_react: assert property (
    MON_OV_I[1] && st.reaction[7] && !WR_I
    |=> !FAIL_SAFE_OUT_N_O && !SYSTEM_RESET_OUT_N_O)
    else $error("monitor two over-voltage reaction wrong");

  // Monitor three under-voltage at 11 drives both outputs.
  a_three_under_both: assert property (
    MON_UV_I[2] && st.reaction[9:8] == `MFR_REACT_BOTH_B && !WR_I
    |=> !FAIL_SAFE_OUT_N_O && !SYSTEM_RESET_OUT_N_O)
    else $error("monitor three under-voltage reaction wrong");

  // Events whose fields are all 00 leave both outputs released.
  a_none_no_effect: assert property (
    (events & {
      |st.reaction[15:14], |st.reaction[13:12],
      |st.reaction[11:10], |st.reaction[9:8],
      |st.reaction[7:6],   |st.reaction[5:4],
      |st.reaction[3:2],   |st.reaction[1:0]}) == 8'h00 && !WR_I
    |=> FAIL_SAFE_OUT_N_O && SYSTEM_RESET_OUT_N_O)
    else $error("output moved for an event set to no effect");

  // Reset loads the default reaction map and releases both outputs.
  a_reset_default: assert property (
    @(posedge CLOCK_I) disable iff (1'b0)
    !NRST_I |=> st.reaction == `MFR_REACT_RESET &&
                SYSTEM_RESET_OUT_N_O && FAIL_SAFE_OUT_N_O)
    else $error("reaction map default not loaded");

  // A read returns the reaction map for one cycle only.
  a_read_reaction: assert property (
    RD_I && ADDR_I == `MFR_OFS_REACTION && !WR_I
    |=> RDATA_O == react_word($past(st.reaction)) ##1
        (RDATA_O == '0 || $past(RD_I)))
    else $error("reaction read data wrong");

  // An unmasked event sets its status bit and raises the interrupt; a mask
  // write in the same cycle may legally take the interrupt away.
  a_status_sticky: assert property (
    (events & st.mask) != 8'h00 && !(WR_I && ADDR_I == `MFR_OFS_MASK)
    |=> IRQ_O && (st.status & $past(events)) == $past(events))
    else $error("event lost or interrupt not raised");

  // Writing ones to the status register clears those bits when idle.
  a_status_clear: assert property (
    WR_I && ADDR_I == `MFR_OFS_STATUS && events == 8'h00
    |=> (st.status & $past(WDATA_I[7:0])) == 8'h00)
    else $error("status bit not cleared by a one");

  // A mask write lands in the next cycle.
  a_mask_write: assert property (
    WR_I && ADDR_I == `MFR_OFS_MASK
    |=> st.mask == $past(WDATA_I[7:0]))
    else $error("mask write lost");

  // With every event masked the interrupt stays low.
  a_irq_masked: assert property (
    st.mask == 8'h00 && !WR_I
    |=> !IRQ_O)
    else $error("interrupt raised while fully masked");

  // Read data is zero in any cycle that does not answer a read.
  a_read_idle: assert property (
    !RD_I
    |=> RDATA_O == '0)
    else $error("read data not zero while idle");

  // Main scenarios.
  c_fs_only: cover property (
    !FAIL_SAFE_OUT_N_O && SYSTEM_RESET_OUT_N_O);
  c_both_out: cover property (
    !FAIL_SAFE_OUT_N_O && !SYSTEM_RESET_OUT_N_O);
  c_clear_vs_set: cover property (
    WR_I && ADDR_I == `MFR_OFS_STATUS && (WDATA_I[7:0] & events) != 8'h00);
  c_irq_rise: cover property ($rose(IRQ_O));

endmodule

// File: logic/mfr_defines.svh
// Holds the offsets, field positions, reset values and widths of the
// monitor fault reaction map.
// Assumes it is included by bare name from the package and the modules.
`ifndef MFR_DEFINES_SVH
`define MFR_DEFINES_SVH

// Widths of the register port, of the event vector and of the reaction fields.
`define MFR_ADDR_W        8
`define MFR_DATA_W        32
`define MFR_EVENTS        8
`define MFR_REACT_W       16

// Byte offsets of the registers.
`define MFR_OFS_REACTION  8'h00
`define MFR_OFS_STATUS    8'h04
`define MFR_OFS_MASK      8'h08
`define MFR_OFS_LIVE      8'h0c

// Lowest bit of the reaction fields inside the bus word.
`define MFR_REACT_LSB     8

// Reset values.
`define MFR_REACT_RESET   16'h9999
`define MFR_STATUS_RESET  8'h00
`define MFR_MASK_RESET    8'h00

// Reaction field encodings.
`define MFR_REACT_NONE    2'b00
`define MFR_REACT_FS      2'b01
`define MFR_REACT_BOTH_A  2'b10
`define MFR_REACT_BOTH_B  2'b11

`endif

// File: logic/mfr_pkg.sv
// Holds the types shared by the monitor fault reaction map modules.
// Assumes the defines header is on the include path.
`include "mfr_defines.svh"

package mfr_pkg;

  typedef logic [`MFR_ADDR_W-1:0]  addr_type;
  typedef logic [`MFR_DATA_W-1:0]  word_type;
  typedef logic [`MFR_EVENTS-1:0]  event_type;
  typedef logic [`MFR_REACT_W-1:0] react_type;
  typedef logic [3:0]              mon_type;

  // Whole state of the top module.
  typedef struct packed {
    react_type reaction;
    event_type status;
    event_type mask;
    word_type  rdata;
    logic      rst_n;
    logic      fs_n;
    logic      irq;
  } state_type;

endpackage

// File: logic/mfr_decode.sv
// Holds the decoder that turns monitor events and their reaction fields
// into reset and fail-safe requests.
// Assumes events are levels synchronous to the caller's clock.
`timescale 1ns/1ns
`include "mfr_defines.svh"

module mfr_decode
  import mfr_pkg::*;
(
  input  wire logic      [`MFR_EVENTS-1:0] events_i,
  input  wire logic      [`MFR_REACT_W-1:0] reaction_i,
  output logic                              reset_req_o,
  output logic                              fs_req_o
);

  // Returns {reset, fail_safe} wanted by one field for an active event.
  function automatic logic [1:0] react(input logic [1:0] field);
    case (field)
      `MFR_REACT_NONE:   react = 2'b00;
      `MFR_REACT_FS:     react = 2'b01;
      `MFR_REACT_BOTH_A: react = 2'b11;
      `MFR_REACT_BOTH_B: react = 2'b11;
      default:           react = 2'b00;
    endcase
  endfunction

  // Any active event ORs in what its own field asks for.
  always_comb begin
    logic [1:0] want;
    want        = 2'b00;
    reset_req_o = 1'b0;
    fs_req_o    = 1'b0;
    for (int i = 0; i < `MFR_EVENTS; i++) begin
      want = events_i[i] ? react(reaction_i[2*i +: 2]) : 2'b00;
      reset_req_o = reset_req_o | want[1];
      fs_req_o    = fs_req_o | want[0];
    end
  end

endmodule

// File: verification/mfr_mcu_model.sv
// Holds a small model of the microcontroller and safety path that sit on
// the far side of the reset and fail-safe outputs.
// Assumes both outputs are active-low levels synchronous to the clock.
`timescale 1ns/1ns

module mfr_mcu_model (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic reset_n_i,
  input  wire logic fail_safe_n_i,
  output int        resets_o,
  output int        safe_o
);
  // Counts each falling edge of the two outputs, as a supervisor would.
  logic reset_q;
  logic safe_q;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      reset_q  <= 1'b1;
      safe_q   <= 1'b1;
      resets_o <= 0;
      safe_o   <= 0;
    end else begin
      reset_q <= reset_n_i;
      safe_q  <= fail_safe_n_i;
      if (reset_q && !reset_n_i) resets_o <= resets_o + 1;
      if (safe_q && !fail_safe_n_i) safe_o <= safe_o + 1;
    end
  end
endmodule

// File: verification/tb_monitor_fault_reaction_map.sv
// Holds the self-checking bench of the monitor fault reaction map.
// Assumes the design package and headers are compiled first.
`timescale 1ns/1ns

module tb_monitor_fault_reaction_map;
  import mfr_pkg::*;
  logic     clk = 1'b0;
  logic     nrst = 1'b0;
  logic     wr = 1'b0;
  logic     rd = 1'b0;
  addr_type addr = '0;
  word_type wdata = '0;
  mon_type  uv = '0;
  mon_type  ov = '0;
  word_type rdata;
  logic     rst_n;
  logic     fs_n;
  logic     irq;
  int       error_cnt = 0;
  int       tests_run = 0;
  int       resets;
  int       safes;

  mfr_top DUT (.CLOCK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .MON_UV_I(uv), .MON_OV_I(ov), .RDATA_O(rdata),
    .SYSTEM_RESET_OUT_N_O(rst_n), .FAIL_SAFE_OUT_N_O(fs_n), .IRQ_O(irq));
  mfr_mcu_model mcu (.clk_i(clk), .nrst_i(nrst), .reset_n_i(rst_n),
    .fail_safe_n_i(fs_n), .resets_o(resets), .safe_o(safes));

  // Makes the 100 MHz clock.
  initial begin
    forever #5 clk = ~clk;
  end

  // Counts a comparison and reports it when it fails.
  task automatic chk(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      error_cnt++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic wr_reg(input addr_type a, input word_type d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input addr_type a, input word_type e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata === e, "read data");
  endtask

  // Drives the eight detections and compares outputs with the model.
  task automatic apply(input int react, input logic [7:0] ev);
    bit r;
    bit f;
    r = 0;
    f = 0;
    for (int k = 0; k < 8; k++) begin
      if (ev[k] && ((react >> 2 * k) & 3) != 0) f = 1;
      if (ev[k] && ((react >> 2 * k) & 3) >= 2) r = 1;
    end
    @(posedge clk);
    uv <= {ev[6], ev[4], ev[2], ev[0]};
    ov <= {ev[7], ev[5], ev[3], ev[1]};
    @(posedge clk);
    #1 chk(rst_n === logic'(!r) && fs_n === logic'(!f), "outputs");
  endtask

  task automatic conclude();
    $display("Counts: %0d checks, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end

  // Main sequence.
  initial begin
    int rv;
    void'($urandom(32'h7b95));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(8'h00, 32'h00999900);
    rd_chk(8'h10, 32'h0);
    apply(16'h9999, 8'h01);
    apply(16'h9999, 8'h02);
    $display("Test defaults done");
    // Every code in every field, each event alone.
    for (int k = 0; k < 8; k++) begin
      for (int c = 0; c < 4; c++) begin
        wr_reg(8'h00, word_type'(c) << (8 + 2 * k));
        apply(c << (2 * k), 8'h01 << k);
        apply(c << (2 * k), 8'h00);
      end
    end
    $display("Test field codes done");
    // Interrupt: raised when unmasked, cleared by writing one.
    wr_reg(8'h04, 32'hff);
    rd_chk(8'h04, 32'h0);
    wr_reg(8'h08, 32'h1);
    rd_chk(8'h08, 32'h1);
    apply(0, 8'h01);
    chk(irq === 1'b1, "irq set");
    // A clear in the same cycle as a held event loses to the event.
    wr_reg(8'h04, 32'h1);
    rd_chk(8'h04, 32'h1);
    apply(0, 8'h00);
    wr_reg(8'h04, 32'h1);
    #1 chk(irq === 1'b0, "irq clear");
    wr_reg(8'h08, 32'h0);
    apply(0, 8'h01);
    chk(irq === 1'b0, "irq masked");
    rd_chk(8'h04, 32'h1);
    rd_chk(8'h0c, 32'h00000301);
    $display("Test interrupt done");
    // Random fields and detections against the model.
    for (int i = 0; i < 40; i++) begin
      rv = $urandom & 16'hffff;
      wr_reg(8'h00, word_type'(rv) << 8);
      apply(rv, 8'($urandom));
    end
    apply(0, 8'h00);
    chk(resets > 0 && safes > 0, "far side saw no fault");
    $display("Test random done");
    // Reset in mid-run restores the defaults and ignores held events.
    wr_reg(8'h00, 32'h00ffff00);
    @(posedge clk);
    nrst <= 1'b0;
    uv   <= 4'hf;
    repeat (2) @(posedge clk);
    #1 chk(rst_n === 1'b1 && fs_n === 1'b1 && irq === 1'b0, "reset outs");
    @(posedge clk);
    nrst <= 1'b1;
    uv   <= '0;
    rd_chk(8'h00, 32'h00999900);
    rd_chk(8'h04, 32'h0);
    apply(16'h9999, 8'h04);
    $display("Test reset done");
    conclude();
  end
endmodule
